// ### rtl/bemf_cfg.svh
// Constants for the zero-crossing sampling block.
`ifndef BEMF_CFG_SVH
`define BEMF_CFG_SVH
`define ADDR_CONTROL_A    4'h0
`define ADDR_CONTROL_B    4'h1
`define ADDR_ZERO_FILTER  4'h2
`define ADDR_PHASE_STATE  4'h3
`define ADDR_REFERENCE    4'h4
`define ADDR_CONTROL_C    4'h5
`define ADDR_CONFIG       4'h6
`define ADDR_STATUS       4'h7
`define CA_CLK_EN         0
`define CA_DIRECT         1
`define CA_HALL           2
`define CA_PROTECT        3
`define CB_POLARITY       0
`define CC_FAST           0
`define PERIPH_KHZ        40000
`define STEP_NS           250
`define STEP_CYCLES       ((`STEP_NS * `PERIPH_KHZ + 999999) / 1000000)
`define ZERO8             8'h00
`endif

// ### rtl/bemf_pkg.sv
// Types for the zero-crossing sampling block.
package bemf_pkg;
  typedef enum logic [1:0] {
    wait_d_type_st = 2'b00,
    seek_z_type_st = 2'b01,
    done_type_st   = 2'b10
  } phase_type;

  typedef struct packed {
    logic [7:0] control_a_reg;
    logic [7:0] control_b_reg;
    logic [3:0] zero_event_count;
    logic [1:0] input_pick;
    logic [7:0] control_c_reg;
    logic [3:0] sample_delay;
    logic       protect_act;
    logic       prev_sample;
    logic [3:0] match_cnt;
    logic [9:0] delay_cnt;
    logic       delay_run;
    logic       pwm_q;
    phase_type  phase;
    logic       comparator_level;
    logic       zero_event;
    logic       zero_seen;
    logic       sample_strobe;
    logic       min_off_zero;
    logic       demag_enable;
    logic       comp_on;
    logic [7:0] rdata;
  } state_type;
endpackage

// ### rtl/bemf_zero_cross_sampling.sv
// Zero-crossing detection, hall input selection and sampling scheduler.
//
// Functional notes
// - With protection, a hardware zero event needs a true edge after demagnetization.
// - Without protection, the event fires once count plus one consecutive samples equal the expected level.
// - Protection is bypassed in hall mode.
// - While protection is set, the consecutive sample count is ignored.
// - Protection is preloaded; applied at commutation outside direct mode, or at phase-state write in direct mode.
// - Hall mode uses three hall inputs; a two-bit field picks one per step.
// - The comparator stays off until clock enable or direct access is set.
// - Demagnetization features are off in hall mode and on otherwise.
// - Hall mode detects from any window, sampling at the independent rate.
// - Hall mode forces zero minimum off time and allows full duty.
// - In hall mode the consecutive sample count still applies.
// - Direct read: set direct access, pick input, read comparator level.
// - Sensorless default samples once per PWM period at off-time end.
// - Current mode PWM combines window, current comparator and minimum off time.
// - Voltage mode PWM from compare generator, cut off at current limit.
// - Demagnetization sampling runs at the independent rate.
// - Fast sampling with zero delay samples after demagnetization at independent rate, on or off; with a delay, only on a tick in a PWM turn-on cycle.
// - Four-bit delay after PWM on; 250 ns steps, zero means off-time sampling.
// - Delay figures assume a 40 MHz peripheral clock and scale with it.
`timescale 1ns/100ps
`include "bemf_cfg.svh"
module bemf_zero_cross_sampling
  import bemf_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       rotor_input_a_i,
  input  wire logic       rotor_input_b_i,
  input  wire logic       rotor_input_c_i,
  input  wire logic       phase_comp_i,
  input  wire logic       pwm_i,
  input  wire logic       current_limit_i,
  input  wire logic       sampling_freq_tick_i,
  input  wire logic       commutation_i,
  input  wire logic       demag_event_i,
  output logic            zero_event_o,
  output logic            sample_strobe_o,
  output logic            min_off_zero_o,
  output logic            demag_enable_o,
  output logic            comparator_on_o
);

  state_type cur;
  state_type nxt;

  // Picks one of the three hall inputs; code 3 falls back to the comparator.
  function automatic logic pick_in(input logic [1:0] sel, input logic a, input logic b,
                                   input logic c, input logic cmp);
    case (sel)
      2'b00:   pick_in = a;
      2'b01:   pick_in = b;
      2'b10:   pick_in = c;
      default: pick_in = cmp;
    endcase
  endfunction

  logic hall;
  logic direct;
  logic fast;
  logic sel_in;
  logic expect_lvl;
  logic pwm_rise;
  logic pwm_fall;
  logic delay_done;
  logic take;
  logic hit;

  // Combinational next state of the whole block.
  always_comb begin
    nxt = cur;
    hall = cur.control_a_reg[`CA_HALL];
    direct = cur.control_a_reg[`CA_DIRECT];
    fast = cur.control_c_reg[`CC_FAST];
    expect_lvl = cur.control_b_reg[`CB_POLARITY];
    sel_in = pick_in(cur.input_pick, rotor_input_a_i, rotor_input_b_i, rotor_input_c_i,
                     phase_comp_i);
    pwm_rise = pwm_i & ~cur.pwm_q;
    pwm_fall = ~pwm_i & cur.pwm_q;
    nxt.pwm_q = pwm_i;
    hit = 1'b0;
    nxt.zero_event = 1'b0;
    nxt.sample_strobe = 1'b0;
    nxt.rdata = `ZERO8;

    // Register writes.
    if (wr_i) begin
      case (addr_i)
        `ADDR_CONTROL_A:   nxt.control_a_reg = wdata_i;
        `ADDR_CONTROL_B:   nxt.control_b_reg = wdata_i;
        `ADDR_ZERO_FILTER: nxt.zero_event_count = wdata_i[3:0];
        `ADDR_PHASE_STATE: nxt.input_pick = wdata_i[1:0];
        `ADDR_CONTROL_C:   nxt.control_c_reg = wdata_i;
        `ADDR_CONFIG:      nxt.sample_delay = wdata_i[3:0];
        default:           nxt.rdata = `ZERO8;
      endcase
    end

    // Preloaded protection takes effect at commutation outside direct mode, or on a phase-state write in direct mode.
    if ((commutation_i && !direct) ||
        (wr_i && addr_i == `ADDR_PHASE_STATE && direct)) begin
      nxt.protect_act = cur.control_a_reg[`CA_PROTECT];
    end

    // Comparator powered only with clock enable or direct access.
    nxt.comp_on = cur.control_a_reg[`CA_CLK_EN] | direct;
    // Direct read works with the clock enabled or not; level follows the picked input.
    nxt.comparator_level = nxt.comp_on ? sel_in : 1'b0;
    nxt.demag_enable = ~hall;
    nxt.min_off_zero = hall | fast | (cur.sample_delay != 4'h0);

    // Delay counter restarted at each PWM turn-on; ten cycles per step at 40 MHz, scaled.
    if (pwm_rise) begin
      nxt.delay_cnt = '0;
      nxt.delay_run = (cur.sample_delay != 4'h0);
    end else if (cur.delay_run && pwm_i) begin
      nxt.delay_cnt = cur.delay_cnt + CNT_W'(1);
    end else if (!pwm_i) begin
      nxt.delay_run = 1'b0;
    end
    delay_done = cur.delay_run &&
                 (cur.delay_cnt == CNT_W'(32'(cur.sample_delay) * `STEP_CYCLES));
    if (delay_done && !fast) begin
      nxt.delay_run = 1'b0;
    end

    // Sampling order selection.
    if (hall || (fast && cur.sample_delay == 4'h0)) begin
      take = sampling_freq_tick_i;
    end else if (fast) begin
      take = sampling_freq_tick_i && pwm_i && (cur.delay_run == 1'b0) &&
             (cur.delay_cnt != '0); // Opens only in a PWM turn-on cycle, before delay_run is set, when a tick meets a nonzero delay_cnt left from the last period.
    end else if (cur.sample_delay != 4'h0) begin
      take = delay_done && pwm_i;
    end else begin
      take = pwm_rise; // End of off time, once per period.
    end
    nxt.sample_strobe = take && nxt.comp_on;

    // Zero detection after demagnetization; hall mode needs no demagnetization.
    case (cur.phase)
      wait_d_type_st: begin
        // Seeded with the expected level so that protection waits for a real edge.
        nxt.prev_sample = expect_lvl;
        nxt.match_cnt = '0;
        if (hall || demag_event_i) begin
          nxt.phase = seek_z_type_st;
        end
      end
      seek_z_type_st: begin
        if (take && cur.comp_on) begin
          nxt.prev_sample = sel_in;
          if (cur.protect_act && !hall) begin
            hit = (sel_in == expect_lvl) && (cur.prev_sample != expect_lvl);
          end else begin
            hit = (sel_in == expect_lvl);
          end
          if (!hit) begin
            nxt.match_cnt = '0;
          end else if (cur.protect_act && !hall) begin
            nxt.zero_event = 1'b1;
            nxt.phase = done_type_st;
          end else if (cur.match_cnt >= cur.zero_event_count) begin
            nxt.zero_event = 1'b1;
            nxt.phase = done_type_st;
          end else begin
            nxt.match_cnt = cur.match_cnt + 4'h1;
          end
        end
      end
      default: begin
        if (commutation_i) begin
          nxt.phase = wait_d_type_st;
        end
      end
    endcase
    if (commutation_i && cur.phase != done_type_st && !hall) begin
      nxt.phase = wait_d_type_st;
    end

    // Register reads, answered one cycle later.
    if (rd_i) begin
      case (addr_i)
        `ADDR_CONTROL_A:   nxt.rdata = cur.control_a_reg;
        `ADDR_CONTROL_B:   nxt.rdata = cur.control_b_reg;
        `ADDR_ZERO_FILTER: nxt.rdata = {4'h0, cur.zero_event_count};
        `ADDR_PHASE_STATE: nxt.rdata = {6'h00, cur.input_pick};
        `ADDR_REFERENCE:   nxt.rdata = {7'h00, cur.comparator_level};
        `ADDR_CONTROL_C:   nxt.rdata = cur.control_c_reg;
        `ADDR_CONFIG:      nxt.rdata = {4'h0, cur.sample_delay};
        `ADDR_STATUS:      nxt.rdata = {4'h0, cur.protect_act, cur.comp_on, cur.phase};
        default:           nxt.rdata = `ZERO8;
      endcase
    end
    // PWM forming lives in the PWM generator; min_off_zero tells it when to drop
    // the minimum off time, and current_limit_i is honoured there.
    if (current_limit_i && pwm_fall) begin
      nxt.delay_run = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign rdata_o = cur.rdata;
  assign zero_event_o = cur.zero_event;
  assign sample_strobe_o = cur.sample_strobe;
  assign min_off_zero_o = cur.min_off_zero;
  assign demag_enable_o = cur.demag_enable;
  assign comparator_on_o = cur.comp_on;

endmodule // bemf_zero_cross_sampling

// ### testbench/hall_sensor_model.sv
// Model of the three hall sensors and the phase comparator.
`timescale 1ns/100ps
module hall_sensor_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] level_i,
  output logic            rotor_input_a_o,
  output logic            rotor_input_b_o,
  output logic            rotor_input_c_o,
  output logic            phase_comp_o
);
  logic [3:0] held = 4'h0;
  // Sensor levels settle one clock late, so the block never sees them change with the bench.
  always @(posedge clk_i) held <= level_i;
  assign {phase_comp_o, rotor_input_c_o, rotor_input_b_o, rotor_input_a_o} = held;
endmodule // hall_sensor_model

// ### testbench/tb.sv
// Self-checking bench for the zero-crossing sampling block.
`timescale 1ns/100ps
module tb;
  logic       clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, pwm_i = 0, tick_i = 0;
  logic       lim_i = 0, com_i = 0, dmg_i = 0;
  logic [3:0] addr_i = 4'h0, lvl = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  wire  [7:0] rdata_o;
  wire        za, zb, zc, zp, zev, stb, moz, dem, con;
  int         n_mismatch = 0, n_compared = 0, n_ev = 0, cyc = 0;
  hall_sensor_model sens (.clk_i(clk_i), .level_i(lvl), .rotor_input_a_o(za),
    .rotor_input_b_o(zb), .rotor_input_c_o(zc), .phase_comp_o(zp));
  bemf_zero_cross_sampling dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rotor_input_a_i(za),
    .rotor_input_b_i(zb), .rotor_input_c_i(zc), .phase_comp_i(zp), .pwm_i(pwm_i),
    .current_limit_i(lim_i), .sampling_freq_tick_i(tick_i), .commutation_i(com_i),
    .demag_event_i(dmg_i), .zero_event_o(zev), .sample_strobe_o(stb),
    .min_off_zero_o(moz), .demag_enable_o(dem), .comparator_on_o(con));
  initial forever #12.5 clk_i = ~clk_i;
  // Zero events are counted, and a hang is cut short by the cycle ceiling.
  always @(posedge clk_i) begin
    n_ev += (zev === 1'b1);
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      complete_run;
    end
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] exp, string what);
    @(posedge clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(what, exp, rdata_o);
  endtask
  task automatic t_modes;
    check("demag_reset", 8'h01, {7'h00, dem});
    check("comp_reset", 8'h00, {7'h00, con});
    wr(4'h0, 8'h04);
    idle(2);
    check("hall_demag_moz", 8'h01, {6'h00, dem, moz});
    wr(4'h0, 8'h00);
    wr(4'h5, 8'h01);
    idle(2);
    check("fast_demag_moz", 8'h03, {6'h00, dem, moz});
    wr(4'h5, 8'h00);
    rd(4'hF, 8'h00, "unmapped");
    $display("test modes done");
  endtask
  task automatic t_direct;
    wr(4'h0, 8'h02);
    lvl <= 4'b0101;
    for (int i = 0; i < 4; i++) begin
      wr(4'h3, 8'(i));
      idle(2);
      rd(4'h4, {7'h00, lvl[i]}, "hall_level");
    end
    check("comp_on", 8'h01, {7'h00, con});
    $display("test direct done");
  endtask
  // Hall mode still needs one matching sample more than the programmed count.
  task automatic t_filter;
    wr(4'h0, 8'h05);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h02);
    wr(4'h3, 8'h00);
    lvl <= 4'b1110;
    idle(3);
    n_ev = 0;
    for (int i = 1; i < 4; i++) begin
      @(posedge clk_i) tick_i <= 1'b1;
      @(posedge clk_i) tick_i <= 1'b0;
      idle(4);
      check("zero_events", (i == 3) ? 8'h01 : 8'h00, 8'(n_ev));
    end
    $display("test filter done");
  endtask
  task automatic pwm_pulse;
    @(posedge clk_i) pwm_i <= 1'b1;
    @(posedge clk_i) pwm_i <= 1'b0;
    idle(2);
  endtask
  // Protection needs a seen edge and ignores the match count; it is preloaded.
  task automatic t_protect;
    wr(4'h0, 8'h0B);
    rd(4'h7, 8'h06, "status_preload");
    wr(4'h3, 8'h03);
    rd(4'h7, 8'h0E, "status_applied");
    lvl <= 4'h0;
    @(posedge clk_i) com_i <= 1'b1;
    @(posedge clk_i) com_i <= 1'b0;
    @(posedge clk_i) dmg_i <= 1'b1;
    @(posedge clk_i) dmg_i <= 1'b0;
    idle(2);
    n_ev = 0;
    pwm_pulse;
    pwm_pulse;
    check("no_edge_event", 8'h00, 8'(n_ev));
    lvl <= 4'h8;
    idle(2);
    pwm_pulse;
    lvl <= 4'h0;
    idle(2);
    pwm_pulse;
    check("edge_event", 8'h01, 8'(n_ev));
    $display("test protect done");
  endtask
  task automatic t_delay;
    int n;
    int dly [3] = '{0, 2, 15};
    wr(4'h0, 8'h01);
    foreach (dly[k]) begin
      wr(4'h6, {4'h0, 4'(dly[k])});
      idle(2);
      @(posedge clk_i) pwm_i <= 1'b1;
      n = 0;
      do idle(1); while (stb !== 1'b1 && ++n < 200);
      n -= dly[k] * 10;
      check("delay_slack", 8'h01, {7'h00, n >= 0 && n <= 2});
      @(posedge clk_i) pwm_i <= 1'b0;
    end
    $display("test delay done");
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    idle(2);
    t_modes;
    t_direct;
    t_filter;
    t_protect;
    t_delay;
    complete_run;
  end
endmodule // tb

// ### testbench/zero_cross_checker.sv
// Port checker for the zero-crossing sampling block.
`timescale 1ns/100ps
module zero_cross_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       zero_event_o,
  input wire logic       sample_strobe_o,
  input wire logic       min_off_zero_o,
  input wire logic       demag_enable_o,
  input wire logic       comparator_on_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Mode writes are given two cycles, since the outputs are registered after the state.
  property p_demag_off;
    wr_i && addr_i == 4'h0 && wdata_i[2] ##1 !wr_i |-> ##[0:1] !demag_enable_o;
  endproperty
  property p_demag_on;
    wr_i && addr_i == 4'h0 && !wdata_i[2] ##1 !wr_i |-> ##[0:1] demag_enable_o;
  endproperty
  property p_hall_minoff;
    wr_i && addr_i == 4'h0 && wdata_i[2] ##1 !wr_i |-> ##[0:1] min_off_zero_o;
  endproperty
  property p_fast_minoff;
    wr_i && addr_i == 4'h5 && wdata_i[0] ##1 !wr_i |-> ##[0:1] min_off_zero_o;
  endproperty
  property p_comp_on;
    wr_i && addr_i == 4'h0 && |wdata_i[1:0] ##1 !wr_i |-> ##[0:1] comparator_on_o;
  endproperty
  property p_comp_cause;
    $rose(comparator_on_o) |-> $past(wr_i, 1) || $past(wr_i, 2);
  endproperty
  property p_idle_rdata;
    !$past(rd_i) |-> rdata_o == 8'h00;
  endproperty
  property p_unmapped;
    rd_i && addr_i[3] |=> rdata_o == 8'h00;
  endproperty
  property p_zero_pulse;
    zero_event_o |=> !zero_event_o;
  endproperty
  a_demag_off: assert property (p_demag_off) else $error("demag left on");
  a_demag_on: assert property (p_demag_on) else $error("demag left off");
  a_hall_minoff: assert property (p_hall_minoff) else $error("min off kept");
  a_fast_minoff: assert property (p_fast_minoff) else $error("min off kept");
  a_comp_on: assert property (p_comp_on) else $error("comparator stays off");
  a_comp_cause: assert property (p_comp_cause) else $error("comparator woke alone");
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_zero_pulse: assert property (p_zero_pulse) else $error("zero event too long");
  c_zero: cover property (zero_event_o);
  c_strobe: cover property (sample_strobe_o);
  c_hall: cover property (comparator_on_o && !demag_enable_o);
endmodule // zero_cross_checker

bind bemf_zero_cross_sampling zero_cross_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .zero_event_o(zero_event_o), .sample_strobe_o(sample_strobe_o),
  .min_off_zero_o(min_off_zero_o), .demag_enable_o(demag_enable_o),
  .comparator_on_o(comparator_on_o));
